// [common/adc_port_pkg.sv]
/*
 * shared constants and types for the converter serial port and sequencer.
 * assumes a 50 MHz system clock; the serial clock is a separate domain.
 */
package adc_port_pkg;

    localparam int unsigned SYS_CLK_HZ      = 50_000_000;       // system clock rate
    localparam int unsigned RESULT_BITS     = 16;               // result width
    localparam int unsigned FRAME_BITS      = 32;               // result plus config readback
    localparam int unsigned CFG_WRITE_POS   = 16;               // config is taken after bit 16

    // idle-clock timeout and early ready release
    localparam int unsigned TIMEOUT_MS      = 28;
    localparam int unsigned READY_LEAD_US   = 8;
    localparam int unsigned TIMEOUT_CYCLES  = TIMEOUT_MS * (SYS_CLK_HZ / 1000);
    localparam int unsigned READY_LEAD_CYC  = READY_LEAD_US * (SYS_CLK_HZ / 1_000_000);

    // conversion period at the default data rate of 128 samples per second
    localparam longint unsigned CONV_TIME_NS = 64'd7_812_500;
    localparam int unsigned CONV_CYCLES =
        int'((CONV_TIME_NS * longint'(SYS_CLK_HZ)) / 64'd1_000_000_000);

    // configuration word layout
    typedef struct packed {
        logic       ss;                 // single-shot start, reads back zero
        logic [2:0] mux_sel;            // input selection, stored only
        logic [2:0] pga_sel;            // gain selection, stored only
        logic       mode;               // 1 = power-down / single shot
        logic [2:0] rate_sel;           // data rate, stored only
        logic       ts_mode;            // temperature mode, stored only
        logic       pull_up_en;         // weak pull-up while deselected
        logic [1:0] write_valid_code;   // must equal WRITE_VALID to update
        logic       unused;             // reads back one
    } cfg_s;

    localparam cfg_s       CFG_RESET   = 16'h058b;
    localparam logic [1:0] WRITE_VALID = 2'h1;
    localparam logic [RESULT_BITS-1:0] RESULT_RESET = 16'h0000;

    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_POWER_DOWN,
        ST_SINGLE_CONV,
        ST_CONTINUOUS
    } seq_state_e;

endpackage

// [src/adc_serial_port_single_shot_ctrl.sv]
/*
 * serial slave port and conversion sequencer of a 16-bit converter.
 * assumes: the analog front end presents a settled sample on sample_in at
 * the end of each conversion period (system clock domain); the serial clock
 * idles low; the pad combines out/oe/pull-up into the shared output pin.
 */
// Functional notes
// - mode bit one selects power-down single shot
// - power-up starts in power-down single shot
// - port answers in power-down, no conversions
// - stays powered down until start bit written
// - start clears flag, runs exactly one conversion
// - single shot returns to power-down when ready
// - start during conversion is ignored
// - mode bit zero starts continuous conversion
// - select high resets port, drops ready output
// - select low shows ready flag after sync delay
// - result locked into shifter for transfer
// - clock low 28 ms resets the port
// - input sampled on falling edge, never driven
// - output bits shift on rising edge
// - output pin low when new result ready
// - unread result releases ready 8 us early
// - pull-up while deselected unless disabled
// - 16-bit result, zero until first conversion
// - bit 15 appears on first rising edge
// - config written only when valid code is 01
// - start flag is bit 15, reads zero
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port_single_shot_ctrl #(
    parameter int unsigned CONV_CYCLES    = adc_port_pkg::CONV_CYCLES,
    parameter int unsigned TIMEOUT_CYCLES = adc_port_pkg::TIMEOUT_CYCLES
) (
    input  wire logic        clk_in,                      // system clock, 50 MHz
    input  wire logic        resetn_in,                   // power-up reset
    input  wire logic        sclk_in,                     // serial clock (link domain)
    input  wire logic        cs_n_in,                     // chip select pin
    input  wire logic        din_in,                      // serial data in pin
    input  wire logic [15:0] sample_in,                   // converted value from front end
    output logic             serial_out_ready_n_out,      // shared data / ready level
    output logic             serial_out_ready_n_oe_out,   // high while the pin is driven
    output logic             serial_out_pull_up_out,      // weak pull-up request
    output logic             converting_out               // conversion in progress
);

    localparam int unsigned NSYNC = 6;                    // synchronised levels
    localparam int unsigned SY_CS = 0;
    localparam int unsigned SY_SCLK = 1;
    localparam int unsigned SY_BUSY = 2;
    localparam int unsigned SY_FIN = 3;
    localparam int unsigned SY_FTOG = 4;
    localparam int unsigned SY_CTOG = 5;
    localparam logic [5:0] FRAME_LAST = 6'(adc_port_pkg::FRAME_BITS);
    localparam logic [5:0] CFG_POS = 6'(adc_port_pkg::CFG_WRITE_POS);
    localparam logic [NSYNC-1:0] SYNC_IDLE = NSYNC'(1) << SY_CS; // select idles high

    // system domain state
    adc_port_pkg::seq_state_e state, next_state;          // sequencer state
    adc_port_pkg::cfg_s       cfg, next_cfg;              // live configuration
    logic [15:0] conversion_result, next_conversion_result; // last result
    logic [31:0] conv_cnt, next_conv_cnt;                 // conversion timer
    logic [31:0] idle_cnt, next_idle_cnt;                 // clock-low timer
    logic        new_data, next_new_data;                 // unread result flag
    logic        timeout_pulse, next_timeout_pulse;       // port reset request
    logic [31:0] snapshot, next_snapshot;                 // word offered to the shifter
    logic        ftog_seen, next_ftog_seen;               // last frame toggle seen
    logic        ctog_seen, next_ctog_seen;               // last config toggle seen
    logic        oe, next_oe;                             // output drive enable
    logic        pull_up, next_pull_up;                   // pull-up request
    logic        converting, next_converting;             // registered conversion flag
    logic [NSYNC-1:0] sync_meta;                          // first synchroniser stage
    logic [NSYNC-1:0] sync_q;                             // second synchroniser stage
    logic [NSYNC-1:0] sync_src;                           // levels to synchronise

    // link domain state
    logic        port_rst_n;                              // async reset of the port
    logic        busy, next_busy;                         // frame under way
    logic [5:0]  bit_cnt, next_bit_cnt;                   // rising edges in this frame
    logic [31:0] shifter, next_shifter;                   // locked outgoing word
    logic        out_bit, next_out_bit;                   // bit on the pin
    logic        frame_tog, next_frame_tog;               // flips at each frame start
    logic [15:0] in_shift, next_in_shift;                 // incoming config bits
    logic [15:0] cfg_word, next_cfg_word;                 // last valid config word
    logic        cfg_tog, next_cfg_tog;                   // flips when cfg_word loads
    logic        finished, next_finished;                 // all frame bits sent

    // select high or idle timeout resets the port at once; the toggles and cfg_word survive
    assign port_rst_n = resetn_in & ~cs_n_in & ~timeout_pulse;

    assign sync_src = {cfg_tog, frame_tog, finished, busy, sclk_in, cs_n_in};

    // two-flop synchronisers; the first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    // idle pin levels, so no false select follows reset
                    sync_meta[g] <= SYNC_IDLE[g];
                    sync_q[g]    <= SYNC_IDLE[g];
                end else begin
                    sync_meta[g] <= sync_src[g];
                    sync_q[g]    <= sync_meta[g];
                end
            end
        end
    endgenerate

    // link side, rising edge: lock the word and shift bits out
    always_comb begin
        next_busy      = busy;
        next_bit_cnt   = bit_cnt;
        next_shifter   = shifter;
        next_out_bit   = out_bit;
        next_frame_tog = frame_tog;
        if (!busy || bit_cnt == FRAME_LAST) begin
            // frame start: take the snapshot whole, msb first
            next_busy      = 1'b1;
            next_shifter   = {snapshot[30:0], 1'b0};
            next_out_bit   = snapshot[31];
            next_bit_cnt   = 6'h01;
            next_frame_tog = port_rst_n ? ~frame_tog : frame_tog; // no flip while deselected
        end else begin
            next_out_bit = shifter[31];
            next_shifter = {shifter[30:0], 1'b0};
            next_bit_cnt = bit_cnt + 6'h01;
        end
    end

    always_ff @(posedge sclk_in or negedge port_rst_n) begin
        if (!port_rst_n) begin
            busy      <= 1'b0;
            bit_cnt   <= 6'h00;
            shifter   <= 32'h0000_0000;
            out_bit   <= 1'b1;
        end else begin
            busy      <= next_busy;
            bit_cnt   <= next_bit_cnt;
            shifter   <= next_shifter;
            out_bit   <= next_out_bit;
        end
    end

    // frame toggle survives select and timeout resets, so the system side
    // only ever sees a flip that a real frame start caused
    always_ff @(posedge sclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_tog <= 1'b0;
        end else begin
            frame_tog <= next_frame_tog;
        end
    end

    // link side, falling edge: sample the input, capture the config word
    always_comb begin
        next_in_shift = {in_shift[14:0], din_in};
        next_cfg_word = cfg_word;
        next_cfg_tog  = cfg_tog;
        next_finished = busy && bit_cnt == FRAME_LAST;
        // only the first 16 bits of a frame may write the configuration
        if (busy && bit_cnt == CFG_POS &&
            next_in_shift[2:1] == adc_port_pkg::WRITE_VALID) begin
            next_cfg_word = next_in_shift;
            next_cfg_tog  = ~cfg_tog;
        end
    end

    // the input shifter and the end-of-frame flag restart with the port
    always_ff @(negedge sclk_in or negedge port_rst_n) begin
        if (!port_rst_n) begin
            in_shift <= 16'h0000;
            finished <= 1'b0;
        end else begin
            in_shift <= next_in_shift;
            finished <= next_finished;
        end
    end

    // config word and its toggle survive the port reset so a write is not lost
    always_ff @(negedge sclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_word <= 16'h0000;
            cfg_tog  <= 1'b0;
        end else begin
            cfg_word <= next_cfg_word;
            cfg_tog  <= next_cfg_tog;
        end
    end

    // system side: sequencer, result, ready flag, timeout, pin control
    always_comb begin
        adc_port_pkg::cfg_s wr;
        logic frame_start;
        wr                     = adc_port_pkg::cfg_s'(cfg_word);
        frame_start            = sync_q[SY_FTOG] != ftog_seen;
        next_state             = state;
        next_cfg               = cfg;
        next_conversion_result = conversion_result;
        next_conv_cnt          = conv_cnt;
        next_new_data          = new_data;
        next_ftog_seen         = sync_q[SY_FTOG];
        next_ctog_seen         = sync_q[SY_CTOG];
        next_idle_cnt          = idle_cnt;
        next_timeout_pulse     = 1'b0;
        next_snapshot          = snapshot;

        // reading out a result consumes the ready flag
        if (frame_start) begin
            next_new_data = 1'b0;
        end

        // conversion timing per state
        unique case (state)
            adc_port_pkg::ST_POWER_DOWN: begin
                next_conv_cnt = 32'h0;
            end
            adc_port_pkg::ST_SINGLE_CONV, adc_port_pkg::ST_CONTINUOUS: begin
                if (conv_cnt == CONV_CYCLES - 1) begin
                    next_conversion_result = sample_in;
                    next_new_data          = 1'b1;
                    next_conv_cnt          = 32'h0;
                    if (state == adc_port_pkg::ST_SINGLE_CONV) begin
                        next_state = adc_port_pkg::ST_POWER_DOWN;
                    end
                end else begin
                    next_conv_cnt = conv_cnt + 32'h1;
                    // unread result is withdrawn shortly before the next one
                    if (state == adc_port_pkg::ST_CONTINUOUS && !frame_start &&
                        conv_cnt == CONV_CYCLES - 1 - adc_port_pkg::READY_LEAD_CYC) begin
                        next_new_data = 1'b0;
                    end
                end
            end
        endcase

        // a new valid configuration word arrived from the port
        if (sync_q[SY_CTOG] != ctog_seen) begin
            next_cfg    = wr;
            next_cfg.ss = 1'b0;
            if (!wr.mode) begin
                if (state != adc_port_pkg::ST_CONTINUOUS) begin
                    next_state    = adc_port_pkg::ST_CONTINUOUS;
                    next_conv_cnt = 32'h0;
                end
            end else if (state == adc_port_pkg::ST_CONTINUOUS) begin
                next_state = adc_port_pkg::ST_POWER_DOWN;
            end else if (state == adc_port_pkg::ST_POWER_DOWN && wr.ss) begin
                next_state    = adc_port_pkg::ST_SINGLE_CONV;
                next_conv_cnt = 32'h0;
            end
            // start while converting falls through untouched
        end

        // serial clock held low too long resets the port once
        if (sync_q[SY_SCLK]) begin
            next_idle_cnt = 32'h0;
        end else if (idle_cnt != TIMEOUT_CYCLES) begin
            next_idle_cnt = idle_cnt + 32'h1;
            next_timeout_pulse = idle_cnt == TIMEOUT_CYCLES - 1;
        end

        // the offered word is frozen while a frame is being shifted
        if (!(sync_q[SY_BUSY] && !sync_q[SY_FIN])) begin
            next_snapshot = {next_conversion_result, 1'b0, next_cfg[14:1], 1'b1};
        end

        next_oe      = !sync_q[SY_CS];
        next_pull_up = sync_q[SY_CS] && cfg.pull_up_en;
        // flag follows the state register exactly, from a flop of its own
        next_converting = next_state != adc_port_pkg::ST_POWER_DOWN;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state             <= adc_port_pkg::ST_POWER_DOWN;
            cfg               <= adc_port_pkg::CFG_RESET;
            conversion_result <= adc_port_pkg::RESULT_RESET;
            conv_cnt          <= 32'h0;
            new_data          <= 1'b0;
            idle_cnt          <= 32'h0;
            timeout_pulse     <= 1'b0;
            snapshot          <= 32'h0;
            ftog_seen         <= 1'b0;
            ctog_seen         <= 1'b0;
            oe                <= 1'b0;
            pull_up           <= 1'b0;
            converting        <= 1'b0;
        end else begin
            state             <= next_state;
            cfg               <= next_cfg;
            conversion_result <= next_conversion_result;
            conv_cnt          <= next_conv_cnt;
            new_data          <= next_new_data;
            idle_cnt          <= next_idle_cnt;
            timeout_pulse     <= next_timeout_pulse;
            snapshot          <= next_snapshot;
            ftog_seen         <= next_ftog_seen;
            ctog_seen         <= next_ctog_seen;
            oe                <= next_oe;
            pull_up           <= next_pull_up;
            converting        <= next_converting;
        end
    end

    // pin level: shifted data mid-frame, otherwise the inverted ready flag;
    // a plain combinational mux, though the data and the flag live in different domains
    // the end flag only clears on the next falling edge, so a frame that
    // follows at once with select low is recognised by its restarted count
    assign serial_out_ready_n_out    = (busy && !(finished && bit_cnt == FRAME_LAST)) ?
                                       out_bit : !new_data;
    assign serial_out_ready_n_oe_out = oe;
    assign serial_out_pull_up_out    = pull_up;
    assign converting_out            = converting;

endmodule
`default_nettype wire

// [sim/adc_port_monitor.sv]
/*
 * concurrent checks on the converter port pins and the sequencer flag.
 * assumes: bound to the port top; cs_n is sampled on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_port_monitor #(
    parameter int unsigned CONV_CYCLES    = 2000,
    parameter int unsigned TIMEOUT_CYCLES = 600
) (
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        sclk_in,
    input wire logic        cs_n_in,
    input wire logic        din_in,
    input wire logic [15:0] sample_in,
    input wire logic        serial_out_ready_n_out,
    input wire logic        serial_out_ready_n_oe_out,
    input wire logic        serial_out_pull_up_out,
    input wire logic        converting_out
);
    // one domain: everything sampled on the system clock
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // deselect must release the pin within the synchroniser delay
    oe_drop_a: assert property ($rose(cs_n_in) |-> ##[1:4] !serial_out_ready_n_oe_out)
        else $error("pin still driven after deselect");
    // a long deselect keeps the pin released
    oe_off_a: assert property (cs_n_in [*5] |-> !serial_out_ready_n_oe_out)
        else $error("pin driven while deselected");
    // a long select drives the pin
    oe_on_a: assert property (!cs_n_in [*5] |-> serial_out_ready_n_oe_out)
        else $error("pin not driven while selected");
    // the driver switches on exactly one synchroniser delay after a select
    oe_cause_a: assert property ($rose(serial_out_ready_n_oe_out) |-> $past(!cs_n_in,3))
        else $error("pin driven without select");
    // no pull-up while the device itself drives
    pull_drop_a: assert property (!cs_n_in [*5] |-> !serial_out_pull_up_out)
        else $error("pull-up left on while selected");
    // pull-up only drops because of a select
    pull_fall_a: assert property ($fell(serial_out_pull_up_out) |-> !cs_n_in)
        else $error("pull-up dropped while deselected");
    // conversions only start from a written word, never on their own
    start_cause_a: assert property ($rose(converting_out) |-> !cs_n_in)
        else $error("conversion started without a transfer");
    // a started conversion is not a glitch
    conv_min_a: assert property ($rose(converting_out) |-> converting_out [*8])
        else $error("conversion ended at once");

    // main scenarios
    cover property ($rose(converting_out));
    cover property ($fell(converting_out));
    cover property ($rose(serial_out_ready_n_oe_out));
endmodule

bind adc_serial_port_single_shot_ctrl adc_port_monitor #(
    .CONV_CYCLES(CONV_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_monitor (
    .clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
    .din_in(din_in), .sample_in(sample_in), .serial_out_ready_n_out(serial_out_ready_n_out),
    .serial_out_ready_n_oe_out(serial_out_ready_n_oe_out),
    .serial_out_pull_up_out(serial_out_pull_up_out), .converting_out(converting_out));
`default_nettype wire

// [sim/adc_host_model.sv]
/*
 * behavioural host master for the converter serial port.
 * assumes: the bench resolves the shared output pin and feeds it back.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    output logic     sclk_out,  // link clock, 64 ns period inside frames only
    output logic     cs_n_out,  // chip select, active low
    output logic     din_out,   // data toward the device
    input wire logic pin_in     // resolved shared output pin
);
    // idle: clock parked low, deselected
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out  = 1'b0;
    end

    // bare clock pulses with din low; select left as the caller set it
    task automatic pulses(input int n);
        din_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b1;
            #32;
            sclk_out = 1'b0;
            #32;
        end
    endtask

    // whole frame; pin is read late in the high phase so the rising shift has landed
    task automatic xfer(input logic [31:0] wr, output logic [31:0] rd);
        cs_n_out = 1'b0;
        #200;
        for (int i = 31; i >= 0; i--) begin
            din_out  = wr[i];
            sclk_out = 1'b1;
            #32;
            rd[i]    = pin_in;
            sclk_out = 1'b0;
            #32;
        end
        #200;
        cs_n_out = 1'b1;
        din_out  = ~din_out;
        #200;
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
/*
 * self-checking bench for the converter serial port and sequencer.
 * assumes: the host model drives the serial pins; short counts set below.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned CONV = 2000;  // shortened conversion period
    localparam int unsigned TMO  = 600;   // shortened idle timeout
    localparam int unsigned LEAD = CONV - adc_port_pkg::READY_LEAD_CYC; // unread flag lifetime
    logic        clk_in;
    logic        resetn_in;
    logic [15:0] sample_in;    // front-end value
    wire         sclk, cs_n, din, dout, dout_oe, pull_up, converting;
    logic        last_pin;     // last driven level, inverted when floating
    wire         pin;          // resolved shared pin
    logic [31:0] rd;           // frame read back
    int          n;
    int          miscompares;
    int          check_count;

    // floating pin shows the inverse of its last value so stale data never passes
    assign pin = dout_oe ? dout : (pull_up ? 1'b1 : ~last_pin);
    always @(posedge clk_in) if (dout_oe) last_pin <= dout;
    always #10 clk_in = ~clk_in;

    adc_serial_port_single_shot_ctrl #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO)) u_dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .din_in(din), .sample_in(sample_in), .serial_out_ready_n_out(dout),
        .serial_out_ready_n_oe_out(dout_oe), .serial_out_pull_up_out(pull_up),
        .converting_out(converting));
    adc_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .pin_in(pin));

    task automatic clks(input int k);
        repeat (k) @(negedge clk_in);
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // bounded wait for a pin level
    task automatic wait_pin(input logic lvl, output int cnt);
        cnt = 0;
        while (pin !== lvl && cnt < 5000) begin
            @(negedge clk_in);
            cnt++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: the whole sequence needs about a quarter of a millisecond
    initial begin
        #1_000_000;
        miscompares++;
        end_sim();
    end

    initial begin
        clk_in = 1'b0;
        resetn_in = 1'b0;
        sample_in = 16'h8001;
        last_pin = 1'b0;
        miscompares = 0;
        check_count = 0;
        clks(8);
        resetn_in = 1'b1;
        clks(4);
        check("converting", converting, 0);
        check("pull_up", pull_up, 1);
        check("oe", dout_oe, 0);
        u_host.xfer(32'h0589_0589, rd);
        check("reset frame", rd, 32'h0000_058b);
        clks(3000);
        check("idle", converting, 0);
        // single shot, then a second start while it runs
        u_host.xfer(32'h858b_858b, rd);
        clks(4);
        check("single", converting, 1);
        u_host.xfer(32'h858b_858b, rd);
        clks(1860); // past the one shot, before a restarted shot would end
        check("one shot", converting, 0);
        u_host.cs_n_out = 1'b0;
        clks(6);
        check("ready", pin, 0);
        u_host.xfer(32'h0589_0589, rd);
        check("shot frame", rd, 32'h8001_058b);
        u_host.cs_n_out = 1'b0;
        clks(6);
        check("not ready", pin, 1);
        // refused write codes, mode zero would start conversions
        for (int c = 0; c < 4; c++) begin
            if (c != 1) begin
                u_host.xfer({2{13'h0090, 2'(c), 1'b1}}, rd);
                clks(6);
                check("bad code", converting, 0);
            end
        end
        u_host.xfer(32'h0589_0589, rd);
        check("cfg kept", rd[15:0], 16'h058b);
        // continuous mode and the early release of an unread result
        sample_in = 16'h1234;
        u_host.xfer(32'h048b_048b, rd);
        clks(4);
        check("continuous", converting, 1);
        u_host.cs_n_out = 1'b0;
        wait_pin(1'b0, n);
        wait_pin(1'b1, n);
        check("lead", 32'(n >= LEAD - 5 && n <= LEAD + 5), 1);
        wait_pin(1'b0, n);
        u_host.xfer(32'h0589_0589, rd);
        check("cont frame", rd, 32'h1234_048b);
        // idle clock timeout after a partial frame
        u_host.cs_n_out = 1'b0;
        u_host.pulses(8);
        clks(TMO + 100);
        u_host.xfer(32'h0589_0589, rd);
        check("timeout", rd, 32'h1234_048b);
        u_host.xfer(32'h058b_058b, rd);
        clks(4);
        check("stop", converting, 0);
        // pull-up off, then an aborted frame
        u_host.xfer(32'h0583_0583, rd);
        clks(6);
        check("no pull", pull_up, 0);
        check("released", dout_oe, 0);
        u_host.cs_n_out = 1'b0;
        u_host.pulses(4);
        u_host.cs_n_out = 1'b1;
        clks(6);
        u_host.xfer(32'h0589_0589, rd);
        check("abort", rd, 32'h1234_0583);
        end_sim();
    end
endmodule
`default_nettype wire
